// >>> src/ppm_pkg.sv
package ppm_pkg;
   // Interface configuration field values (low two bits pick the mode)
   localparam logic [1:0] IFC_PORTS = 2'h0;
   localparam logic [1:0] IFC_WAVE = 2'h2;
   localparam logic [1:0] IFC_FIFO = 2'h3;
   localparam int IFC_W = 3;
   localparam int IFC_WAVE_DB_BIT = 2;
   // Reset values
   localparam logic [IFC_W-1:0] IFC_RESET = 3'h0;
   localparam logic [5:0] POL_RESET = 6'h00;
   localparam logic [2:0] WAKE_RESET = 3'h7;
   // Polarity register field positions
   localparam int POL_B_SELECT = 0;
   localparam int POL_A_SELECT = 1;
   localparam int POL_WR = 2;
   localparam int POL_RD = 3;
   localparam int POL_A_ENABLE = 4;
   localparam int POL_B_ENABLE = 5;
   // Width of the byte-wide ports
   localparam int PORT_W = 8;
   // Pin route selection per port C high pin
   typedef enum logic [2:0] {
      PPM_SEL_PORT = 3'b001,
      PPM_SEL_ALT = 3'b010,
      PPM_SEL_WAVE = 3'b100
   } ppm_sel_t;
endpackage : ppm_pkg

// >>> src/ppm_link_if.sv
`timescale 1ns/1ns
interface ppm_link_if;
   // Link clock, made by the external party
   logic link_clk;
   // Port C high pins, three signals each
   logic [3:0] pc_in;
   logic [3:0] pc_out;
   logic [3:0] pc_oe_n;
   // Port D and port E pins
   logic [7:0] pd_in;
   logic [7:0] pd_out;
   logic [7:0] pd_oe_n;
   logic [7:0] pe_in;
   logic [7:0] pe_out;
   logic [7:0] pe_oe_n;
   // Dedicated pins
   logic waveform_address_bit_five;
   logic [5:0] waveform_ready_in;
   logic [2:0] ctl_out;
   logic wakeup_n;

   modport device (
      input link_clk,
      input pc_in,
      output pc_out,
      output pc_oe_n,
      input pd_in,
      output pd_out,
      output pd_oe_n,
      input pe_in,
      output pe_out,
      output pe_oe_n,
      output waveform_address_bit_five,
      input waveform_ready_in,
      output ctl_out,
      input wakeup_n
   );
   modport partner (
      output link_clk,
      output pc_in,
      input pc_out,
      input pc_oe_n,
      output pd_in,
      input pd_out,
      input pd_oe_n,
      output pe_in,
      input pe_out,
      input pe_oe_n,
      input waveform_address_bit_five,
      output waveform_ready_in,
      input ctl_out,
      output wakeup_n
   );
endinterface : ppm_link_if

// >>> src/ppm_device.sv
// Summary of operation
// - Port C 4..7 pick port, alternate or waveform
// - Timer pins count only with counter select
// - PC6 alternate is low write strobe, control 4
// - PC7 alternate is low read strobe, control 5
// - Port D muxes port, waveform bus, FIFO B
// - Port E 0..4: port, address or FIFO flags
// - Port E 5..7: port or control 3..5
// - Dedicated pin drives waveform address bit five
// - Partner drives ready 0/1 as FIFO selects
// - Partner drives ready 2/3 as output enables
// - Partner drives ready 4/5 as strobes
// - Controls 0..2 may show FIFO level flags
// - FIFO data and controls timed on link clock
// - Wakeup falling edge restarts and interrupts, only while suspended
// - Low wakeup pin blocks suspend entry
// - Clock select picks external or internal clock
// - Software sets FIFO control signal polarity
`timescale 1ns/1ns
module ppm_device (
   // Clocks and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Pin side
   ppm_link_if.device link,
   // Configuration
   input wire logic [3:0] portc_alternate_select,
   input wire logic [3:0] portc_waveform_select,
   input wire logic [ppm_pkg::IFC_W-1:0] interface_configuration_field,
   input wire logic [5:0] fifo_strobe_polarity_register,
   input wire logic interface_clock_source_select,
   input wire logic timer_zero_counter_select,
   input wire logic timer_one_counter_select,
   // General-purpose port state
   input wire logic [3:0] pc_port_out,
   input wire logic [3:0] pc_port_dir,
   input wire logic [7:0] pd_port_out,
   input wire logic [7:0] pd_port_dir,
   input wire logic [7:0] pe_port_out,
   input wire logic [7:0] pe_port_dir,
   output logic [3:0] pc_port_in,
   output logic [7:0] pd_port_in,
   output logic [7:0] pe_port_in,
   // Processor alternate functions
   input wire logic mem_write_n,
   input wire logic mem_read_n,
   output logic timer_zero_count,
   output logic timer_one_count,
   // Waveform engine
   input wire logic [5:0] control_out,
   input wire logic [5:0] waveform_address_out,
   input wire logic [7:0] waveform_second_data_bus_out,
   input wire logic waveform_second_data_bus_drive,
   output logic [7:0] waveform_second_data_bus_in,
   output logic [5:0] ready_in,
   // FIFO B data and flags
   input wire logic [7:0] fifo_b_data_out,
   output logic [7:0] fifo_b_data_in,
   input wire logic a_in_level_flag,
   input wire logic b_in_level_flag,
   input wire logic a_out_level_flag,
   input wire logic b_out_level_flag,
   input wire logic a_in_full_flag,
   input wire logic b_in_full_flag,
   input wire logic a_out_empty_flag,
   input wire logic b_out_empty_flag,
   // Slave FIFO controls, active high after polarity
   output logic fifo_a_select_in,
   output logic fifo_b_select_in,
   output logic fifo_a_output_enable_in,
   output logic fifo_b_output_enable_in,
   output logic slave_fifo_write_strobe,
   output logic slave_fifo_read_strobe,
   // Suspend control
   input wire logic suspended,
   input wire logic suspend_request,
   output logic suspend_enter,
   output logic oscillator_restart,
   output logic wakeup_interrupt
);
   logic [1:0] mode;
   logic fifo_mode;
   logic wave_mode;
   logic [3:0] pc_s1_r;
   logic [3:0] pc_s2_r;
   logic [7:0] pd_s1_r;
   logic [7:0] pd_s2_r;
   logic [7:0] pe_s1_r;
   logic [7:0] pe_s2_r;
   logic [2:0] wk_r;
   logic [5:0] rdy_int_s1_r;
   logic [5:0] rdy_int_s2_r;
   logic [5:0] rdy_l_r;
   logic [7:0] fbd_l_r;
   logic tgl_l_r;
   logic [2:0] tgl_s_r;
   logic word_load;
   logic [5:0] rdy_x_r;
   logic [7:0] fbd_x_r;
   logic [5:0] rdy_pick;
   logic [7:0] fbd_pick;
   logic [5:0] pol;
   ppm_pkg::ppm_sel_t pc_sel [4];

   assign mode = interface_configuration_field[1:0];
   assign fifo_mode = (mode == ppm_pkg::IFC_FIFO);
   assign wave_mode = (mode == ppm_pkg::IFC_WAVE);
   assign pol = fifo_strobe_polarity_register;

   // Pin inputs pass two flops before any logic sees them
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {pc_s1_r, pc_s2_r, pd_s1_r, pd_s2_r} <= 24'h000000;
         {pe_s1_r, pe_s2_r, rdy_int_s1_r, rdy_int_s2_r} <= 28'h0000000;
      end else begin
         {pc_s2_r, pc_s1_r} <= {pc_s1_r, link.pc_in};
         {pd_s2_r, pd_s1_r} <= {pd_s1_r, link.pd_in};
         {pe_s2_r, pe_s1_r} <= {pe_s1_r, link.pe_in};
         rdy_int_s1_r <= link.waveform_ready_in;
         rdy_int_s2_r <= rdy_int_s1_r;
      end
   end

   // Port readback always sees the pin level
   assign pc_port_in = pc_s2_r;
   assign pd_port_in = pd_s2_r;
   assign pe_port_in = pe_s2_r;

   // Timer pins gated by counter select
   assign timer_zero_count = pc_s2_r[0] & timer_zero_counter_select;
   assign timer_one_count = pc_s2_r[1] & timer_one_counter_select;

   // Port C high pins: waveform wins over alternate, else port
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pc
         logic alt_o;
         logic alt_drv;
         logic wave_o;
         assign pc_sel[gi] = portc_waveform_select[gi] ?
            ppm_pkg::PPM_SEL_WAVE : portc_alternate_select[gi] ?
            ppm_pkg::PPM_SEL_ALT : ppm_pkg::PPM_SEL_PORT;
         // Bits 4,5 alternates are timer inputs, so not driven
         assign alt_drv = (gi >= 2);
         assign alt_o = (gi == 2) ? mem_write_n : mem_read_n;
         // Wave outputs: control 1, 3, 4, 5
         assign wave_o = (gi == 0) ? control_out[1] :
                         (gi == 1) ? control_out[3] :
                         (gi == 2) ? control_out[4] : control_out[5];
         always_comb begin
            case (pc_sel[gi])
               ppm_pkg::PPM_SEL_WAVE: begin
                  link.pc_out[gi] = wave_o;
                  link.pc_oe_n[gi] = 1'b0;
               end
               ppm_pkg::PPM_SEL_ALT: begin
                  link.pc_out[gi] = alt_o;
                  link.pc_oe_n[gi] = ~alt_drv;
               end
               default: begin
                  link.pc_out[gi] = pc_port_out[gi];
                  link.pc_oe_n[gi] = ~pc_port_dir[gi];
               end
            endcase
         end
      end
   endgenerate

   // Port D: FIFO B, waveform data bus, or port
   always_comb begin
      if (fifo_mode) begin
         link.pd_out = fifo_b_data_out;
         link.pd_oe_n = {8{~(fifo_b_output_enable_in)}};
      end else if (wave_mode &&
            interface_configuration_field[ppm_pkg::IFC_WAVE_DB_BIT]) begin
         link.pd_out = waveform_second_data_bus_out;
         link.pd_oe_n = {8{~waveform_second_data_bus_drive}};
      end else begin
         link.pd_out = pd_port_out;
         link.pd_oe_n = ~pd_port_dir;
      end
   end
   assign waveform_second_data_bus_in = pd_s2_r;

   // Port E: address, FIFO flags, controls, or port
   always_comb begin
      link.pe_out = pe_port_out;
      link.pe_oe_n = ~pe_port_dir;
      if (fifo_mode) begin
         link.pe_out[4:0] = {b_out_empty_flag, a_out_empty_flag,
            b_in_full_flag, a_in_full_flag, b_out_level_flag};
         link.pe_oe_n[4:0] = 5'h00;
      end else if (wave_mode) begin
         link.pe_out[4:0] = waveform_address_out[4:0];
         link.pe_oe_n[4:0] = 5'h00;
         link.pe_out[7:5] = control_out[5:3];
         link.pe_oe_n[7:5] = 3'h0;
      end
   end

   // Dedicated address pin and control outputs
   assign link.waveform_address_bit_five = waveform_address_out[5];
   assign link.ctl_out = fifo_mode ?
      {a_out_level_flag, b_in_level_flag, a_in_level_flag} :
      control_out[2:0];

   // Ready pins and FIFO B byte captured on the link clock
   always_ff @(posedge link.link_clk or posedge rst) begin
      if (rst) begin
         rdy_l_r <= 6'h00;
         fbd_l_r <= 8'h00;
         tgl_l_r <= 1'b0;
      end else begin
         rdy_l_r <= link.waveform_ready_in;
         fbd_l_r <= link.pd_in;
         tgl_l_r <= ~tgl_l_r;
      end
   end

   // Toggle handshake: words taken only once the toggle has synced;
   // a link clock faster than about 3 system clocks would drop words
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tgl_s_r <= 3'h0;
         rdy_x_r <= 6'h00;
         fbd_x_r <= 8'h00;
      end else begin
         tgl_s_r <= {tgl_s_r[1:0], tgl_l_r};
         if (word_load) begin
            rdy_x_r <= rdy_l_r;
            fbd_x_r <= fbd_l_r;
         end
      end
   end
   assign word_load = tgl_s_r[2] ^ tgl_s_r[1];

   // Clock source select: external capture or internal sampling
   assign rdy_pick = interface_clock_source_select ? rdy_x_r :
      rdy_int_s2_r;
   assign fbd_pick = interface_clock_source_select ? fbd_x_r : pd_s2_r;
   assign ready_in = rdy_pick;
   assign fifo_b_data_in = fbd_pick;

   // FIFO controls decoded with software polarity
   assign fifo_a_select_in = fifo_mode &
      (rdy_pick[0] ~^ pol[ppm_pkg::POL_A_SELECT]);
   assign fifo_b_select_in = fifo_mode &
      (rdy_pick[1] ~^ pol[ppm_pkg::POL_B_SELECT]);
   assign fifo_a_output_enable_in = fifo_mode &
      (rdy_pick[2] ~^ pol[ppm_pkg::POL_A_ENABLE]);
   assign fifo_b_output_enable_in = fifo_mode &
      (rdy_pick[3] ~^ pol[ppm_pkg::POL_B_ENABLE]);
   assign slave_fifo_write_strobe = fifo_mode &
      (rdy_pick[4] ~^ pol[ppm_pkg::POL_WR]);
   assign slave_fifo_read_strobe = fifo_mode &
      (rdy_pick[5] ~^ pol[ppm_pkg::POL_RD]);

   // Wakeup pin: sync, then falling-edge detect on the synced copy
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wk_r <= ppm_pkg::WAKE_RESET;
      end else begin
         wk_r <= {wk_r[1:0], link.wakeup_n};
      end
   end
   assign oscillator_restart = suspended & wk_r[2] & ~wk_r[1];
   assign wakeup_interrupt = oscillator_restart;
   // Held-low wakeup vetoes suspend entry
   assign suspend_enter = suspend_request & wk_r[1];
endmodule : ppm_device

// >>> src/ppm_partner.sv
`timescale 1ns/1ns
module ppm_partner #(
   parameter int CLK_DIV = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Pin side
   ppm_link_if.partner link,
   // User side
   input wire logic fifo_a_select,
   input wire logic fifo_b_select,
   input wire logic fifo_a_oe,
   input wire logic fifo_b_oe,
   input wire logic fifo_write,
   input wire logic fifo_read,
   input wire logic [3:0] pc_drive,
   input wire logic [7:0] pd_drive,
   input wire logic [7:0] pe_drive,
   input wire logic wakeup_request,
   output logic [7:0] pd_seen,
   output logic [2:0] ctl_seen
);
   logic [7:0] div_r;
   logic clk_r;

   // Link clock made by dividing the local clock
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_r <= 8'h00;
         clk_r <= 1'b0;
      end else if (div_r == 8'(CLK_DIV - 1)) begin
         div_r <= 8'h00;
         clk_r <= ~clk_r;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
   assign link.link_clk = clk_r;

   // FIFO controls driven as ready pins, timed to the link clock
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         link.waveform_ready_in <= 6'h00;
      end else if (div_r == 8'(CLK_DIV - 1) && clk_r) begin
         link.waveform_ready_in <= {fifo_read, fifo_write, fifo_b_oe,
            fifo_a_oe, fifo_b_select, fifo_a_select};
      end
   end

   // Pin data and wakeup
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         link.pc_in <= 4'h0;
         link.pd_in <= 8'h00;
         link.pe_in <= 8'h00;
         link.wakeup_n <= 1'b1;
         pd_seen <= 8'h00;
         ctl_seen <= 3'h0;
      end else begin
         link.pc_in <= pc_drive;
         link.pd_in <= pd_drive;
         link.pe_in <= pe_drive;
         link.wakeup_n <= ~wakeup_request;
         pd_seen <= link.pd_out;
         ctl_seen <= link.ctl_out;
      end
   end
endmodule : ppm_partner

// >>> test/ppm_link_properties.sv
`timescale 1ns/1ns
module ppm_link_properties (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Link pins
   input wire logic link_clk,
   input wire logic [3:0] pc_out,
   input wire logic [3:0] pc_oe_n,
   input wire logic [7:0] pe_out,
   input wire logic [7:0] pe_oe_n,
   input wire logic waveform_address_bit_five,
   input wire logic [5:0] waveform_ready_in,
   input wire logic [2:0] ctl_out,
   // Device-side causes
   input wire logic [ppm_pkg::IFC_W-1:0] interface_configuration_field,
   input wire logic [3:0] portc_alternate_select,
   input wire logic [3:0] portc_waveform_select,
   input wire logic [5:0] control_out,
   input wire logic [5:0] waveform_address_out,
   input wire logic [7:0] pe_port_out,
   input wire logic [7:0] pe_port_dir,
   input wire logic mem_write_n,
   input wire logic mem_read_n,
   input wire logic a_in_level_flag,
   input wire logic b_in_level_flag,
   input wire logic a_out_level_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Mode is taken from the low two configuration bits only
   wire logic [1:0] mode = interface_configuration_field[1:0];

   // Pin outputs checked against the sources that should own them
   AST_ADR_FIVE: assert property (
      waveform_address_bit_five == waveform_address_out[5])
      else $error("address bit five wrong");
   AST_CTL_FLAGS: assert property (
      mode == ppm_pkg::IFC_FIFO |->
      ctl_out == {a_out_level_flag, b_in_level_flag, a_in_level_flag})
      else $error("level flags not on control pins");
   AST_CTL_WAVE: assert property (
      mode != ppm_pkg::IFC_FIFO |-> ctl_out == control_out[2:0])
      else $error("control pins wrong outside fifo mode");
   AST_PE_ADDR: assert property (
      mode == ppm_pkg::IFC_WAVE |-> pe_oe_n[4:0] == 5'h00 &&
      pe_out[4:0] == waveform_address_out[4:0])
      else $error("port E address bits wrong");
   AST_PE_CTL: assert property (
      mode == ppm_pkg::IFC_WAVE |->
      pe_oe_n[7:5] == 3'h0 && pe_out[7:5] == control_out[5:3])
      else $error("port E control bits wrong");
   AST_PE_PORT: assert property (
      mode[1] == 1'b0 |-> pe_out == pe_port_out && pe_oe_n == ~pe_port_dir)
      else $error("port E not following port bits");
   AST_PC_LOW: assert property (
      portc_waveform_select[1:0] == 2'h3 |-> pc_oe_n[1:0] == 2'h0 &&
      pc_out[1:0] == {control_out[3], control_out[1]})
      else $error("port C low pins not on control outputs");
   AST_PC_SIX: assert property (
      portc_waveform_select[2] || portc_alternate_select[2] |->
      !pc_oe_n[2] && pc_out[2] ==
      (portc_waveform_select[2] ? control_out[4] : mem_write_n))
      else $error("port C six source wrong");
   AST_PC_SEVEN: assert property (
      portc_waveform_select[3] || portc_alternate_select[3] |->
      !pc_oe_n[3] && pc_out[3] ==
      (portc_waveform_select[3] ? control_out[5] : mem_read_n))
      else $error("port C seven source wrong");
   // Ready pins move only away from the link clock rising edge
   AST_READY_STEADY: assert property (
      $rose(link_clk) |-> $stable(waveform_ready_in))
      else $error("ready pins moved at link clock rise");

   C_FIFO: cover property (mode == ppm_pkg::IFC_FIFO && ctl_out != 3'h0);
   C_WAVE: cover property (mode == ppm_pkg::IFC_WAVE);
   C_LINK: cover property ($rose(link_clk));
endmodule : ppm_link_properties

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic sys_clk, rst, mem_write_n, mem_read_n, suspended, suspend_request;
   logic interface_clock_source_select, timer_zero_counter_select;
   logic timer_one_counter_select, waveform_second_data_bus_drive;
   logic [3:0] portc_alternate_select, portc_waveform_select, pc_port_out;
   logic [3:0] pc_port_dir, pc_port_in, pc_drive;
   logic [2:0] interface_configuration_field, ctl_seen;
   logic [5:0] fifo_strobe_polarity_register, control_out, ready_in, req;
   logic [5:0] waveform_address_out;
   logic [7:0] pd_port_out, pd_port_dir, pe_port_out, pe_port_dir, pd_port_in;
   logic [7:0] pe_port_in, waveform_second_data_bus_out, fifo_b_data_out;
   logic [7:0] waveform_second_data_bus_in, fifo_b_data_in, pd_drive;
   logic [7:0] pe_drive, pd_seen, flg;
   logic a_in_level_flag, b_in_level_flag, a_out_level_flag, b_out_level_flag;
   logic a_in_full_flag, b_in_full_flag, a_out_empty_flag, b_out_empty_flag;
   logic timer_zero_count, timer_one_count, suspend_enter, oscillator_restart;
   logic wakeup_interrupt, fifo_a_select_in, fifo_b_select_in;
   logic fifo_a_output_enable_in, fifo_b_output_enable_in;
   logic slave_fifo_write_strobe, slave_fifo_read_strobe;
   logic fifo_a_select, fifo_b_select, fifo_a_oe, fifo_b_oe, fifo_write;
   logic fifo_read, wakeup_request;
   int fails, checks_done;

   // Flags packed so top bits match control pins, low bits port E
   assign {a_out_level_flag, b_in_level_flag, a_in_level_flag,
      b_out_empty_flag, a_out_empty_flag, b_in_full_flag, a_in_full_flag,
      b_out_level_flag} = flg;
   // Partner requests in ready pin order 0..5
   assign {fifo_read, fifo_write, fifo_b_oe, fifo_a_oe, fifo_b_select,
      fifo_a_select} = req;
   wire logic [5:0] fctl = {slave_fifo_read_strobe, slave_fifo_write_strobe,
      fifo_b_output_enable_in, fifo_a_output_enable_in, fifo_b_select_in,
      fifo_a_select_in};

   ppm_link_if lnk ();
   ppm_device u_ppm_device (.link(lnk), .*);
   ppm_partner #(.CLK_DIV(8)) u_ppm_partner (.link(lnk), .*);
   ppm_link_properties u_ppm_link_properties (.link_clk(lnk.link_clk),
      .pc_out(lnk.pc_out), .pc_oe_n(lnk.pc_oe_n), .pe_out(lnk.pe_out),
      .pe_oe_n(lnk.pe_oe_n), .ctl_out(lnk.ctl_out),
      .waveform_address_bit_five(lnk.waveform_address_bit_five),
      .waveform_ready_in(lnk.waveform_ready_in), .*);

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk(logic [7:0] got, logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Wait edges, then park on the falling edge so outputs have settled
   task automatic go(int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : go

   task automatic tally_and_finish();
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic t_ports();
      chk(lnk.pd_oe_n, 8'hFF);
      chk({lnk.pc_oe_n, lnk.pe_oe_n[3:0]}, 8'hFF);
      @(posedge sys_clk);
      pe_port_dir <= 8'hF0;
      pe_port_out <= 8'hA5;
      pe_drive <= 8'h3C;
      pd_drive <= 8'h5A;
      pc_port_dir <= 4'hF;
      pc_port_out <= 4'h6;
      go(40);
      chk({lnk.pe_out[7:4], lnk.pe_oe_n[7:4]}, 8'hA0);
      chk({lnk.pc_out, lnk.pc_oe_n}, 8'h60);
      chk(pe_port_in[3:0], 4'hC);
      chk(pd_port_in, 8'h5A);
   endtask : t_ports

   // Port C routes, then timer inputs with select off and on
   task automatic t_portc();
      @(posedge sys_clk);
      control_out <= 6'h2A;
      mem_write_n <= 1'b0;
      portc_waveform_select <= 4'hF;
      go(1);
      chk({lnk.pc_out, lnk.pc_oe_n}, 8'hB0);
      @(posedge sys_clk);
      portc_waveform_select <= 4'h0;
      portc_alternate_select <= 4'hF;
      pc_drive <= 4'h3;
      go(40);
      chk({lnk.pc_out[3:2], lnk.pc_oe_n}, 6'h23);
      chk({timer_one_count, timer_zero_count}, 2'h0);
      chk(pc_port_in, 4'h3);
      @(posedge sys_clk);
      timer_zero_counter_select <= 1'b1;
      timer_one_counter_select <= 1'b1;
      go(40);
      chk({timer_one_count, timer_zero_count}, 2'h3);
   endtask : t_portc

   task automatic t_modes();
      @(posedge sys_clk);
      flg <= 8'hA6;
      waveform_address_out <= 6'h35;
      pe_port_dir <= 8'hFF;
      for (int m = 0; m < 8; m++) begin
         @(posedge sys_clk);
         interface_configuration_field <= 3'(m);
         go(1);
         if (m[1:0] == 2'h3) begin
            chk(lnk.ctl_out, 3'h5);
            chk(ctl_seen, 3'h5);
            chk(lnk.pe_out[4:0], 5'h06);
         end else if (m[1:0] == 2'h2) begin
            chk(lnk.pe_out, 8'hB5);
            chk(lnk.ctl_out, 3'h2);
         end else begin
            chk(lnk.pe_out, 8'hA5);
         end
         chk(lnk.waveform_address_bit_five, 1'b1);
      end
      // Wide waveform mode: second data bus both ways
      @(posedge sys_clk);
      interface_configuration_field <= 3'h6;
      waveform_second_data_bus_out <= 8'h69;
      waveform_second_data_bus_drive <= 1'b1;
      go(40);
      chk(lnk.pd_oe_n, 8'h00);
      chk(pd_seen, 8'h69);
      @(posedge sys_clk);
      waveform_second_data_bus_drive <= 1'b0;
      pd_drive <= 8'hC3;
      go(40);
      chk(waveform_second_data_bus_in, 8'hC3);
      // FIFO B capture on each clock source
      for (int c = 0; c < 2; c++) begin
         @(posedge sys_clk);
         interface_configuration_field <= 3'h3;
         interface_clock_source_select <= c[0];
         pd_drive <= 8'h96 ^ 8'(c);
         go(40);
         chk(fifo_b_data_in, 8'h96 ^ 8'(c));
      end
   endtask : t_modes

   task automatic fc(logic [5:0] pol, logic [2:0] ifc, logic [5:0] exp);
      @(posedge sys_clk);
      fifo_strobe_polarity_register <= pol;
      interface_configuration_field <= ifc;
      req <= 6'h3F;
      go(40);
      chk(fctl, exp);
      chk(ready_in, 6'h3F);
   endtask : fc

   // Suspend held off by low wakeup; one restart and one interrupt
   task automatic t_wake();
      int hits;
      int ints;
      hits = 0;
      ints = 0;
      @(posedge sys_clk);
      suspended <= 1'b1;
      suspend_request <= 1'b1;
      go(8);
      chk(suspend_enter, 1'b1);
      @(posedge sys_clk);
      wakeup_request <= 1'b1;
      repeat (60) begin
         @(negedge sys_clk);
         if (oscillator_restart === 1'b1) hits++;
         if (wakeup_interrupt === 1'b1) ints++;
      end
      chk(8'(hits), 8'h01);
      chk(8'(ints), 8'h01);
      chk(suspend_enter, 1'b0);
   endtask : t_wake

   initial begin
      {rst, mem_write_n, mem_read_n} = 3'h7;
      {suspended, suspend_request, interface_clock_source_select,
         timer_zero_counter_select, timer_one_counter_select,
         waveform_second_data_bus_drive, wakeup_request} = 7'h00;
      {portc_alternate_select, portc_waveform_select, pc_port_out,
         pc_port_dir, pc_drive} = 20'h00000;
      {interface_configuration_field, fifo_strobe_polarity_register,
         control_out, waveform_address_out, req} = 27'h0;
      {pd_port_out, pd_port_dir, pe_port_out, pe_port_dir, flg, pd_drive,
         waveform_second_data_bus_out, fifo_b_data_out, pe_drive} = 72'h0;
      fails = 0;
      checks_done = 0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      go(4);
      t_ports();
      t_portc();
      t_modes();
      fc(6'h3F, 3'h3, 6'h3F);
      fc(6'h00, 3'h3, 6'h00);
      fc(6'h15, 3'h3, 6'h16);
      fc(6'h3F, 3'h0, 6'h00);
      t_wake();
      tally_and_finish();
   end
endmodule : tb_top
